/* logic/t2c_pkg.sv */
package t2c_pkg;

  // ****************************************
  // Register indices (byte address = index * 4)
  // ****************************************
  localparam logic [7:0] IDX_CONTROL      = 8'hc8;
  localparam logic [7:0] IDX_MODE_CONTROL = 8'hc9;
  localparam logic [7:0] IDX_RCOMP_LOW    = 8'hca;
  localparam logic [7:0] IDX_RCOMP_HIGH   = 8'hcb;
  localparam logic [7:0] IDX_COUNT_LOW    = 8'hcc;
  localparam logic [7:0] IDX_COUNT_HIGH   = 8'hcd;
  localparam logic [7:0] IDX_CAP_ENFLAG   = 8'hd0;
  localparam logic [7:0] IDX_CAP_EDGE     = 8'hd1;
  localparam logic [7:0] IDX_CAP_FILTER   = 8'hd2;
  localparam logic [7:0] IDX_CAP0_LOW     = 8'hd3;
  localparam logic [7:0] IDX_CAP0_HIGH    = 8'hd4;
  localparam logic [7:0] IDX_CAP1_LOW     = 8'hd5;
  localparam logic [7:0] IDX_CAP1_HIGH    = 8'hd6;
  localparam logic [7:0] IDX_INT_ENABLE   = 8'hd7;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTL_FLAG_BIT    = 7;
  localparam int CTL_RUN_BIT     = 2;
  localparam int CTL_CPSEL_BIT   = 0;
  localparam int MOD_RLDEN_BIT   = 7;
  localparam int MOD_DIV_LSB     = 4;
  localparam int MOD_CAPCLR_BIT  = 3;
  localparam int MOD_CMPCLR_BIT  = 2;
  localparam int MOD_TRIG_LSB    = 0;
  localparam int CAP_EN_LSB      = 4;
  localparam int CAP_FLAG_LSB    = 0;
  localparam int FILT_EN_LSB     = 4;
  localparam int IE_CAP_BIT      = 0;
  localparam int IE_GLOBAL_BIT   = 1;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_MAX     = 16'hffff;
  localparam logic [1:0]  EDGE_FALL     = 2'h0;
  localparam logic [1:0]  EDGE_RISE     = 2'h1;
  localparam logic [1:0]  EDGE_BOTH     = 2'h2;
  localparam logic [1:0]  TRIG_OVERFLOW = 2'h0;
  localparam logic [1:0]  TRIG_CAP0     = 2'h1;
  localparam logic [1:0]  TRIG_CAP1     = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int FILTER_CLKS   = 4;
  localparam int PRESCALE_BITS = 9;

endpackage

/* logic/t2c_capture_channel.sv */
`timescale 1ns/10ps
module t2c_capture_channel
  import t2c_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Pin and configuration
  input  wire logic       pin,
  input  wire logic       filter_en,
  input  wire logic [1:0] edge_sel,
  // Event
  output logic            edge_pulse
);

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       level;
    logic [2:0] cnt;
    logic       pulse;
  } t2c_chan_t;

  t2c_chan_t s_q;
  t2c_chan_t s_d;
  logic      next_level;

  // ****************************************
  // Filter and edge detection
  // ****************************************

  // Filter watches only the second stage, never the first
  always_comb begin
    s_d        = s_q;
    next_level = s_q.level;
    s_d.sync1  = pin;
    s_d.sync2  = s_q.sync1;
    if (!filter_en) begin
      next_level = s_q.sync2;
      s_d.cnt    = 3'h0;
    end else if (s_q.sync2 == s_q.level) begin
      s_d.cnt = 3'h0; // Glitch ended early, start over
    end else if (s_q.cnt == 3'(FILTER_CLKS - 1)) begin
      next_level = s_q.sync2; // Stable four clocks
      s_d.cnt    = 3'h0;
    end else begin
      s_d.cnt = s_q.cnt + 3'h1;
    end
    s_d.level = next_level;
    // Per-channel edge choice, reserved code never fires
    case (edge_sel)
      EDGE_FALL: s_d.pulse = s_q.level & ~next_level;
      EDGE_RISE: s_d.pulse = ~s_q.level & next_level;
      EDGE_BOTH: s_d.pulse = s_q.level ^ next_level;
      default:   s_d.pulse = 1'b0;
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign edge_pulse = s_q.pulse;

endmodule

/* logic/t2c_timer2.sv */
// Behaviour
// - Reload enable loads reload pair on event
// - Prescaler divides by four up to 512
// - Capture auto-clear zeroes counter on capture
// - Compare auto-clear zeroes counter after match
// - Trigger field picks overflow or channel
// - Reload pair is match or reload value
// - Counter readable and writable as bytes
// - Mode from select and reload enable bits
// - Optional filter rejects pulses under four clocks
// - Independent edge detector per channel
// - Disabled channel neither captures nor flags
// - Capture copies count into channel registers
// - Capture edge sets channel flag
// - Capture interrupt needs flag and enables
// - Capture completes before auto-clear
// - Run bit gates counting, halt keeps count
// - Timer flag sticky on overflow or match
// - Edge codes fall, rise, both, reserved
`timescale 1ns/10ps
module t2c_timer2
  import t2c_pkg::*;
#(
  parameter int CHANNELS = 2
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Capture pins
  input  wire logic        capture_input_0,
  input  wire logic        capture_input_1,
  // Status outputs
  output logic             timer2_flag,
  output logic             capture_irq
);

  typedef struct packed {
    logic [7:0]  control;
    logic [7:0]  mode_control;
    logic [15:0] reload_compare;
    logic [15:0] count;
    logic [1:0]  cap_enable;
    logic [1:0]  cap_flag;
    logic [3:0]  edge_sel;
    logic [1:0]  filter_en;
    logic [15:0] cap0;
    logic [15:0] cap1;
    logic [1:0]  int_enable;
    logic [PRESCALE_BITS-1:0] prescale;
    logic        ack;
    logic [7:0]  rdata;
  } t2c_state_t;

  // Writable control bits; the reserved ones always read back zero
  localparam logic [7:0] CTL_WMASK = 8'((1 << CTL_FLAG_BIT) | (1 << CTL_RUN_BIT) | (1 << CTL_CPSEL_BIT));

  // Every register comes out of reset at zero, prescaler and handshake included
  localparam t2c_state_t STATE_RESET = '{
    control:        REG_RESET,
    mode_control:   REG_RESET,
    reload_compare: COUNT_RESET,
    count:          COUNT_RESET,
    cap_enable:     2'h0,
    cap_flag:       2'h0,
    edge_sel:       4'h0,
    filter_en:      2'h0,
    cap0:           COUNT_RESET,
    cap1:           COUNT_RESET,
    int_enable:     2'h0,
    prescale:       '0,
    ack:            1'h0,
    rdata:          REG_RESET
  };

  t2c_state_t s_q;
  t2c_state_t s_d;

  logic [1:0] pins;
  logic [1:0] edge_ev;
  logic [1:0] cap_ev;
  logic       req;
  logic       wr_en;
  logic       running;
  logic       compare_mode;
  logic       reload_mode;
  logic       tick;
  logic       overflow;
  logic       match;
  logic       reload_ev;
  logic [PRESCALE_BITS-1:0] div_mask;
  logic [7:0] wbyte;

  // Register index hit on the word address
  // Low two address bits are ignored
  function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
    return addr[9:2] == idx;
  endfunction

  // Read mux for one index
  // Unmapped indices and reserved bits read as zero
  function automatic logic [7:0] read_mux(input t2c_state_t s, input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      IDX_CONTROL:      v = s.control;
      IDX_MODE_CONTROL: v = s.mode_control;
      IDX_RCOMP_LOW:    v = s.reload_compare[7:0];
      IDX_RCOMP_HIGH:   v = s.reload_compare[15:8];
      IDX_COUNT_LOW:    v = s.count[7:0];
      IDX_COUNT_HIGH:   v = s.count[15:8];
      IDX_CAP_ENFLAG:   v = {2'b00, s.cap_enable, 2'b00, s.cap_flag};
      IDX_CAP_EDGE:     v = {4'h0, s.edge_sel};
      IDX_CAP_FILTER:   v = {2'b00, s.filter_en, 4'h0};
      IDX_CAP0_LOW:     v = s.cap0[7:0];
      IDX_CAP0_HIGH:    v = s.cap0[15:8];
      IDX_CAP1_LOW:     v = s.cap1[7:0];
      IDX_CAP1_HIGH:    v = s.cap1[15:8];
      IDX_INT_ENABLE:   v = {6'h00, s.int_enable};
      default:          v = 8'h00;
    endcase
    return v;
  endfunction

  // ****************************************
  // Capture channels
  // ****************************************

  assign pins = {capture_input_1, capture_input_0};

  // Each channel has its own filter and edge detector
  // Pin, event and field widths assume two channels
  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    t2c_capture_channel u_chan (
      .clk        (clk),
      .rst        (rst),
      .pin        (pins[i]),
      .filter_en  (s_q.filter_en[i]),
      .edge_sel   (s_q.edge_sel[2*i +: 2]),
      .edge_pulse (edge_ev[i])
    );
  end

  // ****************************************
  // Bus handshake
  // ****************************************

  // One wait cycle, answer on the second edge
  // A request still held after its answer starts a fresh access
  // Only the low byte of write data matters; the rest is dropped
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~s_q.ack;
  assign wr_en           = avs_write & s_q.ack;
  assign wbyte           = avs_writedata[7:0];
  assign avs_readdata    = {24'h000000, s_q.rdata};

  // ****************************************
  // Timer decode
  // ****************************************

  // Mode table:
  //   select 0, reload enable 0 : input capture
  //   select 0, reload enable 1 : auto-reload
  //   select 1, either          : compare
  // Mode from select and reload enable
  assign compare_mode = s_q.control[CTL_CPSEL_BIT];
  assign reload_mode  = ~compare_mode & s_q.mode_control[MOD_RLDEN_BIT];
  assign running      = s_q.control[CTL_RUN_BIT];

  // Divide by 4 << code: mask of low prescaler bits
  // Changing the code while running may stretch one period
  assign div_mask = PRESCALE_BITS'((1 << (s_q.mode_control[MOD_DIV_LSB +: 3] + 2)) - 1);
  assign tick     = running & ((s_q.prescale & div_mask) == div_mask);

  // Disabled channel is ignored entirely
  assign cap_ev   = edge_ev & s_q.cap_enable;
  assign overflow = tick & (s_q.count == COUNT_MAX);
  assign match    = tick & compare_mode & (s_q.count == s_q.reload_compare);

  // Reload acts only in auto-reload mode, never in compare mode
  // Reload trigger choice, code 11 never reloads
  always_comb begin
    case (s_q.mode_control[MOD_TRIG_LSB +: 2])
      TRIG_OVERFLOW: reload_ev = overflow;
      TRIG_CAP0:     reload_ev = cap_ev[0];
      TRIG_CAP1:     reload_ev = cap_ev[1];
      default:       reload_ev = 1'b0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************

  // One pass holds every hardware update; the bus write wins except over the flag sets made after it
  always_comb begin
    s_d       = s_q;
    s_d.ack   = req & ~s_q.ack;
    // Read data prepared in the wait cycle, stable at the answer edge
    if (avs_read & ~s_q.ack) begin
      s_d.rdata = read_mux(s_q, avs_address[9:2]);
    end

    // Prescaler free runs only while enabled, restarts on halt
    // A restart therefore always waits a full divided period
    if (running) begin
      s_d.prescale = s_q.prescale + PRESCALE_BITS'(1);
    end else begin
      s_d.prescale = '0;
    end

    // Counter: capture clear beats reload beats count
    // A capture with auto-clear set never reloads
    if (|cap_ev && s_q.mode_control[MOD_CAPCLR_BIT]) begin
      s_d.count = COUNT_RESET; // Captured value is the old count
    end else if (reload_mode && reload_ev) begin
      s_d.count = s_q.reload_compare;
    end else if (match && s_q.mode_control[MOD_CMPCLR_BIT]) begin
      s_d.count = COUNT_RESET;
    end else if (tick) begin
      s_d.count = s_q.count + 16'h0001; // Wraps to zero on overflow
    end

    // Captures work in every mode while the channel is enabled
    // Capture copies the current count
    if (cap_ev[0]) begin
      s_d.cap0 = s_q.count;
    end
    if (cap_ev[1]) begin
      s_d.cap1 = s_q.count;
    end

    // Software writes, byte wide; unmapped writes dropped
    if (wr_en) begin
      if (hit(avs_address, IDX_CONTROL)) begin
        s_d.control = wbyte & CTL_WMASK;
      end
      if (hit(avs_address, IDX_MODE_CONTROL)) begin
        s_d.mode_control = wbyte;
      end
      if (hit(avs_address, IDX_RCOMP_LOW)) begin
        s_d.reload_compare[7:0] = wbyte;
      end
      if (hit(avs_address, IDX_RCOMP_HIGH)) begin
        s_d.reload_compare[15:8] = wbyte;
      end
      // Byte access while running may tear; software should halt
      // No latch joins the two bytes; each write lands on its own
      if (hit(avs_address, IDX_COUNT_LOW)) begin
        s_d.count[7:0] = wbyte;
      end
      if (hit(avs_address, IDX_COUNT_HIGH)) begin
        s_d.count[15:8] = wbyte;
      end
      if (hit(avs_address, IDX_CAP_ENFLAG)) begin
        s_d.cap_enable = wbyte[CAP_EN_LSB +: 2];
        s_d.cap_flag   = wbyte[CAP_FLAG_LSB +: 2]; // Software clears
      end
      if (hit(avs_address, IDX_CAP_EDGE)) begin
        s_d.edge_sel = wbyte[3:0];
      end
      if (hit(avs_address, IDX_CAP_FILTER)) begin
        s_d.filter_en = wbyte[FILT_EN_LSB +: 2];
      end
      if (hit(avs_address, IDX_INT_ENABLE)) begin
        s_d.int_enable = wbyte[1:0];
      end
    end

    // Hardware sets win over a clearing write
    // so an event in the cycle of a clear is never lost
    s_d.cap_flag = s_d.cap_flag | cap_ev;
    if (overflow || match) begin
      s_d.control[CTL_FLAG_BIT] = 1'b1;
    end
  end

  // ****************************************
  // State register
  // ****************************************

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= STATE_RESET; // Async branch loads constants only
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  // Interrupt stays up until every capture flag or either enable bit is cleared
  assign timer2_flag = s_q.control[CTL_FLAG_BIT];
  assign capture_irq = (|s_q.cap_flag) & s_q.int_enable[IE_CAP_BIT] & s_q.int_enable[IE_GLOBAL_BIT];

endmodule

/* tb/t2c_timer2_props.sv */
`timescale 1ns/10ps
module t2c_timer2_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Bus handshake
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Status
  input wire logic        timer2_flag,
  input wire logic        capture_irq
);
  // ********************
  // Port checks
  // ********************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Steps of one access: request, then acceptance
  sequence s_req;
    avs_read || avs_write;
  endsequence
  sequence s_acc;
    s_req ##0 !avs_waitrequest;
  endsequence

  AST_WAIT_FIRST: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("access lacks its single wait");
  AST_WAIT_BOUND: assert property (s_req |-> ##[0:1] !avs_waitrequest)
    else $error("access not answered in time");
  AST_NEW_ACCESS: assert property (s_acc |=> avs_waitrequest || !(avs_read || avs_write))
    else $error("held request accepted twice");
  AST_IDLE_READY: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait raised while idle");
  AST_RD_UPPER: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_RD_HOLD: assert property (!avs_read && !$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data moved without a read");
  AST_FLAG_STICKY: assert property ($fell(timer2_flag) |-> $past(avs_write && !avs_waitrequest))
    else $error("timer flag cleared by hardware");
  AST_IRQ_CLEAR: assert property ($fell(capture_irq) |-> $past(avs_write && !avs_waitrequest))
    else $error("capture interrupt dropped by hardware");
endmodule

bind t2c_timer2 t2c_timer2_chk i_chk (
  .clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .timer2_flag(timer2_flag), .capture_irq(capture_irq)
);

/* tb/t2c_pulse_src.sv */
`timescale 1ns/10ps
module t2c_pulse_src (
  // Clock
  input wire logic       clk,
  // Command
  input wire logic       go,
  input wire logic [7:0] width,
  // Capture pin
  output logic           pin
);
  // ********************
  // Pulse source
  // ********************
  logic [7:0] left_q = 8'h0;

  // A command loads the pulse length; counting down keeps the pin high
  always @(posedge clk) begin
    left_q <= go ? width : left_q - {7'h0, left_q != 8'h0};
  end

  // Pin rests low between pulses
  assign pin = left_q != 8'h0;
endmodule

/* tb/t2c_timer2_bench.sv */
`timescale 1ns/10ps
module t2c_timer2_bench;
  // ********************
  // Bench
  // ********************
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  adr = 10'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic        wt;
  logic [1:0]  go = 2'h0;
  logic [7:0]  wid = 8'h1;
  wire [1:0]   pin;
  logic        flag;
  logic        irq;
  logic [7:0]  v;
  logic [31:0] expq[$];
  logic [7:0]  ovm[4] = '{8'h00, 8'h80, 8'h83, 8'h81};
  logic [15:0] ovc[4] = '{16'h2, 16'h1236, 16'h2, 16'h2};
  logic [7:0]  cpm[3] = '{8'h00, 8'h04, 8'h84};
  logic [15:0] cpc[3] = '{16'h5, 16'h1, 16'h1};
  int          errors = 0;
  int          checks = 0;
  int          seed = 67;

  // 50 MHz clock
  always #10 clk = ~clk;

  t2c_timer2 #(.CHANNELS(2)) i_dut (
    .clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(wt), .capture_input_0(pin[0]), .capture_input_1(pin[1]),
    .timer2_flag(flag), .capture_irq(irq)
  );
  // Pulse sources on both capture pins
  t2c_pulse_src i_src0 (.clk(clk), .go(go[0]), .width(wid), .pin(pin[0]));
  t2c_pulse_src i_src1 (.clk(clk), .go(go[1]), .width(wid), .pin(pin[1]));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One access, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    adr <= {idx, 2'h0};
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wt) @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic put(input logic [7:0] idx, input logic [7:0] d);
    acc(1'b1, idx, d);
  endtask

  task automatic get(input logic [7:0] idx, input logic [7:0] e);
    expq.push_back({24'h0, e});
    acc(1'b0, idx, 8'h0);
  endtask

  task automatic pair(input logic [7:0] idx, input logic [15:0] d);
    put(idx, d[7:0]);
    put(idx + 8'h1, d[15:8]);
  endtask

  // Run for j ticks and a half, then halt; halting keeps the count
  task automatic run(input logic [7:0] ctl, md, input int j, input logic [15:0] cnt, input logic f);
    int p;
    p = 4 << md[6:4];
    put(8'hc9, md);
    put(8'hc8, ctl);
    repeat (p * j + p / 2 - 6) @(posedge clk);
    get(8'hc8, {f, 7'h0} | ctl);
    cmp({31'h0, flag}, {31'h0, f});
    put(8'hc8, 8'h00);
    get(8'hcc, cnt[7:0]);
    get(8'hcd, cnt[15:8]);
  endtask

  task automatic pulse(input int ch, input logic [7:0] w);
    @(posedge clk);
    wid <= w;
    go[ch] <= 1'b1;
    @(posedge clk);
    go <= 2'h0;
    repeat (12) @(posedge clk);
  endtask

  task automatic final_report;
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Answered reads meet the oldest note
  always @(posedge clk)
    if (rd && !wt) cmp(rdat, expq.pop_front());

  // Hang guard
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    final_report();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) get(8'(8'hc8 + i), 8'h00);
    get(8'hff, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      put(8'(8'hca + i), v);
      get(8'(8'hca + i), v);
    end
    for (int c = 0; c < 8; c++) begin
      pair(8'hcc, 16'h0);
      run(8'h04, 8'(c << 4), 3, 16'h3, 1'b0);
    end
    pair(8'hca, 16'h1234);
    for (int i = 0; i < 4; i++) begin
      pair(8'hcc, 16'hffff);
      run(8'h04, ovm[i], 3, ovc[i], 1'b1);
    end
    pair(8'hca, 16'h3);
    for (int i = 0; i < 3; i++) begin
      pair(8'hcc, 16'h0);
      run(8'h05, cpm[i], 5, cpc[i], 1'b1);
    end
    put(8'hc9, 8'h00);
    pair(8'hcc, 16'h5678);
    put(8'hd1, 8'h05);
    put(8'hd0, 8'h10);
    pulse(0, 8'h4);
    get(8'hd3, 8'h78);
    get(8'hd4, 8'h56);
    get(8'hd0, 8'h11);
    put(8'hd7, 8'h03);
    @(posedge clk);
    cmp({31'h0, irq}, 32'h1);
    put(8'hd7, 8'h01);
    @(posedge clk);
    cmp({31'h0, irq}, 32'h0);
    put(8'hd0, 8'h10);
    pulse(1, 8'h4);
    get(8'hd0, 8'h10);
    get(8'hd5, 8'h00);
    put(8'hd2, 8'h10);
    pulse(0, 8'h3);
    get(8'hd0, 8'h10);
    pulse(0, 8'h4);
    get(8'hd0, 8'h11);
    pair(8'hca, 16'h1234);
    pair(8'hcc, 16'h0abc);
    put(8'hc9, 8'h81);
    pulse(0, 8'h4);
    get(8'hcc, 8'h34);
    get(8'hcd, 8'h12);
    put(8'hc9, 8'h89);
    pulse(0, 8'h4);
    get(8'hd3, 8'h34);
    get(8'hcc, 8'h00);
    get(8'hcd, 8'h00);
    for (int e = 0; e < 4; e++) begin
      put(8'hd1, 8'(e << 2));
      put(8'hd0, 8'h20);
      pulse(1, 8'h1e);
      get(8'hd0, 8'h20 | {6'h0, (e == 1 || e == 2), 1'b0});
      put(8'hd0, 8'h20);
      repeat (30) @(posedge clk);
      get(8'hd0, 8'h20 | {6'h0, (e == 0 || e == 2), 1'b0});
    end
    put(8'hc9, 8'h00);
    pair(8'hcc, 16'h9abc);
    put(8'hd1, 8'h04);
    put(8'hd0, 8'h20);
    pulse(1, 8'h4);
    get(8'hd5, 8'hbc);
    get(8'hd6, 8'h9a);
    final_report();
  end
endmodule
